// File: tldf_regs.sv
// Purpose: Limit, operating-point and dynamic fan-start control registers
// Assumes: All inputs synchronous to clk; ce gates every state update
// Notes: Read data is registered, one cycle behind the address
`timescale 1ns/10ps
module tldf_regs #(
    parameter int DW = 8,
    parameter int NCH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DW-1:0] reg_wdata,
    output logic [DW-1:0] reg_rdata_q,
    input wire logic lock_bit,
    input wire logic overheat_signal_pin,
    input wire logic [NCH-1:0][DW-1:0] channel_temp,
    input wire logic [NCH-1:0][DW-1:0] zone_low_limit,
    input wire logic [NCH-1:0][DW-1:0] zone_high_limit,
    input wire logic [NCH-1:0][DW-1:0] floor_base,
    input wire logic monitor_tick,
    output logic [NCH-1:0][DW-1:0] fan_start_temperature_q,
    input wire logic [DW-1:0] core_voltage,
    input wire logic [DW-1:0] core_voltage_low_limit,
    input wire logic standby_power,
    input wire logic undervolt_alert_mask,
    output logic undervolt_status_set_q,
    output logic undervolt_alert_q,
    output logic cpu_hot_monitor_enable_q,
    output logic shutdown_block_q,
    input wire logic poll_start,
    input wire logic poll_done,
    output logic poll_req_q,
    output logic [7:0] poll_client_addr_q,
    output logic poll_dual_zone_q
);
    import tldf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Byte registers and three fixed channels are all the map can hold
    if (DW != 8) begin : g_bad_dw
        $error("tldf_regs: DW must be 8");
    end
    if (NCH != TLDF_NCH) begin : g_bad_nch
        $error("tldf_regs: NCH must be 3");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [DW-1:0] term_lo_q;
    logic [DW-1:0] term_hi_q;
    logic [DW-1:0] curr_lo_q;
    logic [DW-1:0] curr_hi_q;
    logic [DW-1:0] pcfg2_q;
    logic [DW-1:0] proc_op_q;
    logic [DW-1:0] ch_op_q [NCH];
    logic [DW-1:0] dctl1_q;
    logic [DW-1:0] dctl2_q;
    logic wr_ok;
    logic overheat_q;
    logic overheat_rise;
    logic undervolt;
    logic undervolt_q;

    // Writes are only taken while unlocked
    assign wr_ok = ce & reg_wr & ~lock_bit;

    // Limit registers, plain storage for the limit comparators elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            term_lo_q <= TLDF_RST_LO;
            term_hi_q <= TLDF_RST_HI;
            curr_lo_q <= TLDF_RST_LO;
            curr_hi_q <= TLDF_RST_HI;
        end else if (wr_ok) begin
            if (reg_addr == TLDF_OFS_TERM_LO) begin
                term_lo_q <= reg_wdata;
            end
            if (reg_addr == TLDF_OFS_TERM_HI) begin
                term_hi_q <= reg_wdata;
            end
            if (reg_addr == TLDF_OFS_CURR_LO) begin
                curr_lo_q <= reg_wdata;
            end
            if (reg_addr == TLDF_OFS_CURR_HI) begin
                curr_hi_q <= reg_wdata;
            end
        end
    end

    // Processor interface configuration; low bits are kept but unused
    always_ff @(posedge clk) begin
        if (rst) begin
            pcfg2_q <= TLDF_RST_PCFG2;
        end else if (wr_ok && reg_addr == TLDF_OFS_PCFG2) begin
            pcfg2_q <= reg_wdata;
        end
    end

    // Processor operating point
    always_ff @(posedge clk) begin
        if (rst) begin
            proc_op_q <= TLDF_RST_PROC_OP;
        end else if (wr_ok && reg_addr == TLDF_OFS_PROC_OP) begin
            proc_op_q <= reg_wdata;
        end
    end

    // Dynamic control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            dctl1_q <= TLDF_RST_DCTL;
            dctl2_q <= TLDF_RST_DCTL;
        end else if (wr_ok) begin
            if (reg_addr == TLDF_OFS_DCTL1) begin
                dctl1_q <= reg_wdata;
            end
            if (reg_addr == TLDF_OFS_DCTL2) begin
                dctl2_q <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overheat pin edge

    // Capture only on the rising edge so a held pin does not keep
    // overwriting a point that software later reprograms
    always_ff @(posedge clk) begin
        if (rst) begin
            overheat_q <= 1'b0;
        end else if (ce) begin
            overheat_q <= overheat_signal_pin;
        end
    end
    assign overheat_rise = overheat_signal_pin & ~overheat_q;

    ////////////////////////////////////////////////////////////////////////
    // Core voltage low safeguard

    // Only armed while running from standby with the guard bit set
    assign undervolt = dctl1_q[TLDF_UNDERVOLT_BIT] & standby_power &
                       (core_voltage < core_voltage_low_limit);

    // Suspension lifts on its own once the voltage recovers
    always_ff @(posedge clk) begin
        if (rst) begin
            undervolt_q <= 1'b0;
            undervolt_status_set_q <= 1'b0;
            undervolt_alert_q <= 1'b0;
            cpu_hot_monitor_enable_q <= 1'b1;
            shutdown_block_q <= 1'b0;
        end else if (ce) begin
            undervolt_q <= undervolt;
            undervolt_status_set_q <= undervolt & ~undervolt_q;
            undervolt_alert_q <= undervolt & ~undervolt_alert_mask;
            cpu_hot_monitor_enable_q <= ~undervolt;
            shutdown_block_q <= undervolt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel operating point and dynamic fan-start loop

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [2:0] code;
        logic [11:0] dec_wait;
        logic [11:0] inc_wait;
        logic [11:0] cnt_q;
        logic capture;
        logic dyn_on;
        logic hot;
        logic cool;
        logic [7:0] op_ofs;

        // Cycle code assembly; remote 2 is split over both registers
        if (i == 0) begin : g_r1
            assign code = dctl2_q[TLDF_R1_CODE_LSB +: 3];
            assign op_ofs = TLDF_OFS_R1_OP;
        end else if (i == 1) begin : g_loc
            assign code = dctl2_q[TLDF_LOC_CODE_LSB +: 3];
            assign op_ofs = TLDF_OFS_LOC_OP;
        end else begin : g_r2
            assign code = {dctl1_q[TLDF_R2_CODE_MSB_BIT],
                           dctl2_q[TLDF_R2_CODE_LSB +: 2]};
            assign op_ofs = TLDF_OFS_R2_OP;
        end

        // Each code step doubles both waits
        assign dec_wait = TLDF_DEC_BASE << code;
        assign inc_wait = TLDF_INC_BASE << code;

        assign capture = dctl1_q[TLDF_CAPTURE_LSB + i] &
                         overheat_rise;
        // Suspended while the undervolt safeguard holds
        assign dyn_on = dctl1_q[TLDF_ENABLE_LSB + i] &
                        ~undervolt;
        assign hot = channel_temp[i] > ch_op_q[i];
        assign cool = channel_temp[i] < zone_low_limit[i];

        // Capture beats a software write landing in the same cycle
        always_ff @(posedge clk) begin
            if (rst) begin
                ch_op_q[i] <= TLDF_RST_CH_OP;
            end else if (ce && capture) begin
                ch_op_q[i] <= channel_temp[i];
            end else if (wr_ok && reg_addr == op_ofs) begin
                ch_op_q[i] <= reg_wdata;
            end
        end

        // Monitoring cycles since the last adjustment
        always_ff @(posedge clk) begin
            if (rst) begin
                cnt_q <= TLDF_CNT_ZERO;
            end else if (ce) begin
                if (!dyn_on || (!hot && !cool)) begin
                    cnt_q <= TLDF_CNT_ZERO;
                end else if (monitor_tick) begin
                    if ((hot && cnt_q + TLDF_CNT_ONE >= dec_wait) ||
                        (!hot && cnt_q + TLDF_CNT_ONE >= inc_wait)) begin
                        cnt_q <= TLDF_CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + TLDF_CNT_ONE;
                    end
                end
            end
        end

        // Hot lowers the start point so fans spin earlier; cool raises it
        // but never past the zone high limit
        always_ff @(posedge clk) begin
            if (rst) begin
                fan_start_temperature_q[i] <= TLDF_FLOOR_MIN;
            end else if (ce) begin
                if (!dyn_on) begin
                    fan_start_temperature_q[i] <= floor_base[i];
                end else if (monitor_tick && hot &&
                             cnt_q + TLDF_CNT_ONE >= dec_wait) begin
                    if (fan_start_temperature_q[i] != TLDF_FLOOR_MIN) begin
                        fan_start_temperature_q[i] <=
                            fan_start_temperature_q[i] - TLDF_ONE;
                    end
                end else if (monitor_tick && cool &&
                             cnt_q + TLDF_CNT_ONE >= inc_wait) begin
                    if (fan_start_temperature_q[i] < zone_high_limit[i]) begin
                        fan_start_temperature_q[i] <=
                            fan_start_temperature_q[i] + TLDF_ONE;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Processor client poller

    tldf_poll_e poll_state_q;
    logic [1:0] poll_idx_q;
    logic [1:0] cpu_count;

    assign cpu_count = pcfg2_q[TLDF_CPU_COUNT_LSB +: 2];

    // Walks clients in address order, one request per client
    always_ff @(posedge clk) begin
        if (rst) begin
            poll_state_q <= TLDF_POLL_IDLE;
            poll_idx_q <= 2'h0;
            poll_req_q <= 1'b0;
            poll_client_addr_q <= TLDF_CLIENT_BASE;
            poll_dual_zone_q <= 1'b0;
        end else if (ce) begin
            poll_req_q <= 1'b0;
            case (poll_state_q)
                TLDF_POLL_IDLE: begin
                    if (poll_start) begin
                        poll_idx_q <= 2'h0;
                        poll_state_q <= TLDF_POLL_REQ;
                    end
                end
                TLDF_POLL_REQ: begin
                    poll_req_q <= 1'b1;
                    poll_client_addr_q <= TLDF_CLIENT_BASE +
                                          {6'h00, poll_idx_q};
                    case (poll_idx_q)
                        2'h1: poll_dual_zone_q <=
                            pcfg2_q[TLDF_CPU2_DUAL_BIT];
                        2'h2: poll_dual_zone_q <=
                            pcfg2_q[TLDF_CPU3_DUAL_BIT];
                        2'h3: poll_dual_zone_q <=
                            pcfg2_q[TLDF_CPU4_DUAL_BIT];
                        default: poll_dual_zone_q <= 1'b0;
                    endcase
                    poll_state_q <= TLDF_POLL_WAIT;
                end
                TLDF_POLL_WAIT: begin
                    if (poll_done) begin
                        if (poll_idx_q == cpu_count) begin
                            poll_state_q <= TLDF_POLL_IDLE;
                        end else begin
                            poll_idx_q <= poll_idx_q + 2'h1;
                            poll_state_q <= TLDF_POLL_REQ;
                        end
                    end
                end
                default: begin
                    poll_state_q <= TLDF_POLL_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    // Registered so the output comes from a flop; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_q <= TLDF_READ_NONE;
        end else if (ce) begin
            case (reg_addr)
                TLDF_OFS_TERM_LO: reg_rdata_q <= term_lo_q;
                TLDF_OFS_CURR_LO: reg_rdata_q <= curr_lo_q;
                TLDF_OFS_TERM_HI: reg_rdata_q <= term_hi_q;
                TLDF_OFS_CURR_HI: reg_rdata_q <= curr_hi_q;
                TLDF_OFS_PCFG2: reg_rdata_q <= pcfg2_q;
                TLDF_OFS_PROC_OP: reg_rdata_q <= proc_op_q;
                TLDF_OFS_R1_OP: reg_rdata_q <= ch_op_q[0];
                TLDF_OFS_LOC_OP: reg_rdata_q <= ch_op_q[1];
                TLDF_OFS_R2_OP: reg_rdata_q <= ch_op_q[2];
                TLDF_OFS_DCTL1: reg_rdata_q <= dctl1_q;
                TLDF_OFS_DCTL2: reg_rdata_q <= dctl2_q;
                default: reg_rdata_q <= TLDF_READ_NONE;
            endcase
        end
    end
endmodule

// File: tldf_pkg.sv
// Purpose: Shared constants for the thermal limit and dynamic floor bank
// Assumes: Byte-wide registers on the device's own register port
// Notes: Offsets are the device register addresses
package tldf_pkg;
    // Register offsets
    localparam logic [7:0] TLDF_OFS_TERM_LO = 8'h84;
    localparam logic [7:0] TLDF_OFS_CURR_LO = 8'h85;
    localparam logic [7:0] TLDF_OFS_TERM_HI = 8'h86;
    localparam logic [7:0] TLDF_OFS_CURR_HI = 8'h87;
    localparam logic [7:0] TLDF_OFS_PCFG2 = 8'h88;
    localparam logic [7:0] TLDF_OFS_PROC_OP = 8'h8A;
    localparam logic [7:0] TLDF_OFS_R1_OP = 8'h8B;
    localparam logic [7:0] TLDF_OFS_LOC_OP = 8'h8C;
    localparam logic [7:0] TLDF_OFS_R2_OP = 8'h8D;
    localparam logic [7:0] TLDF_OFS_DCTL1 = 8'h8E;
    localparam logic [7:0] TLDF_OFS_DCTL2 = 8'h8F;
    // Reset values
    localparam logic [7:0] TLDF_RST_LO = 8'h00;
    localparam logic [7:0] TLDF_RST_HI = 8'hFF;
    localparam logic [7:0] TLDF_RST_PCFG2 = 8'h00;
    localparam logic [7:0] TLDF_RST_PROC_OP = 8'hFB;
    localparam logic [7:0] TLDF_RST_CH_OP = 8'h64;
    localparam logic [7:0] TLDF_RST_DCTL = 8'h00;
    localparam logic [7:0] TLDF_READ_NONE = 8'h00;
    // Processor interface configuration fields
    localparam int TLDF_CPU4_DUAL_BIT = 3;
    localparam int TLDF_CPU3_DUAL_BIT = 4;
    localparam int TLDF_CPU2_DUAL_BIT = 5;
    localparam int TLDF_CPU_COUNT_LSB = 6;
    localparam logic [7:0] TLDF_CLIENT_BASE = 8'h30;
    // Dynamic control 1 fields
    localparam int TLDF_R2_CODE_MSB_BIT = 0;
    localparam int TLDF_UNDERVOLT_BIT = 1;
    localparam int TLDF_CAPTURE_LSB = 2;
    localparam int TLDF_ENABLE_LSB = 5;
    // Dynamic control 2 fields
    localparam int TLDF_R1_CODE_LSB = 0;
    localparam int TLDF_LOC_CODE_LSB = 3;
    localparam int TLDF_R2_CODE_LSB = 6;
    // Wait between adjustments, in monitoring cycles, at code 000
    localparam logic [11:0] TLDF_DEC_BASE = 12'h008;
    localparam logic [11:0] TLDF_INC_BASE = 12'h010;
    localparam logic [7:0] TLDF_FLOOR_MIN = 8'h00;
    localparam logic [7:0] TLDF_ONE = 8'h01;
    localparam logic [11:0] TLDF_CNT_ZERO = 12'h000;
    localparam logic [11:0] TLDF_CNT_ONE = 12'h001;
    // Channel indices: remote 1, local, remote 2
    localparam int TLDF_NCH = 3;
    // Poller states
    typedef enum logic [2:0] {
        TLDF_POLL_IDLE = 3'b001,
        TLDF_POLL_REQ = 3'b010,
        TLDF_POLL_WAIT = 3'b100
    } tldf_poll_e;
endpackage

// File: tldf_poll_client.sv
// Purpose: Processor thermal client answering the bank's poll requests
// Assumes: One request outstanding at a time
// Notes: slow stretches each answer so the poller has to wait
`timescale 1ns/10ps
module tldf_poll_client (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic poll_req_q,
    output logic poll_done
);
    logic busy_q;
    logic [3:0] wait_q;
    // Count down after a request, then answer with a one-cycle pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            wait_q <= 4'h0;
            poll_done <= 1'b0;
        end else begin
            poll_done <= 1'b0;
            if (poll_req_q) begin
                busy_q <= 1'b1;
                wait_q <= slow ? 4'h9 : 4'h0;
            end else if (busy_q && wait_q == 4'h0) begin
                busy_q <= 1'b0;
                poll_done <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule

// File: tldf_regs_chk.sv
// Purpose: Port assertions for the limit and dynamic floor bank
// Assumes: One clock, synchronous active-high reset
// Notes: Undervolt latency is judged over a window, not one edge
`timescale 1ns/10ps
module tldf_regs_chk #(
    parameter int DW = 8,
    parameter int NCH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DW-1:0] reg_rdata_q,
    input wire logic lock_bit,
    input wire logic monitor_tick,
    input wire logic [NCH-1:0][DW-1:0] floor_base,
    input wire logic [NCH-1:0][DW-1:0] fan_start_temperature_q,
    input wire logic [DW-1:0] core_voltage,
    input wire logic [DW-1:0] core_voltage_low_limit,
    input wire logic undervolt_alert_mask,
    input wire logic undervolt_status_set_q,
    input wire logic undervolt_alert_q,
    input wire logic cpu_hot_monitor_enable_q,
    input wire logic shutdown_block_q,
    input wire logic poll_done,
    input wire logic poll_req_q,
    input wire logic [7:0] poll_client_addr_q
);
    import tldf_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // Locked write to a limit leaves its read value alone
    // Read before the edge and read after it must match
    property p_lock_hold;
        (ce && reg_wr && lock_bit && reg_addr == TLDF_OFS_TERM_LO)
        ##1 reg_addr == TLDF_OFS_TERM_LO
        |=> reg_rdata_q == $past(reg_rdata_q);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked write changed a limit");
    // Without a tick the floor may only move to the programmed base
    property p_floor_src;
        !$past(monitor_tick) && $changed(fan_start_temperature_q[0])
        |-> fan_start_temperature_q[0] == $past(floor_base[0]);
    endproperty
    a_floor_src: assert property (p_floor_src)
        else $error("floor moved without a tick");
    // A dynamic adjustment is a single degree step
    property p_floor_step;
        $past(monitor_tick) && $changed(fan_start_temperature_q[0])
        && fan_start_temperature_q[0] != $past(floor_base[0])
        |-> fan_start_temperature_q[0] == $past(fan_start_temperature_q[0])
        - TLDF_ONE || fan_start_temperature_q[0]
        == $past(fan_start_temperature_q[0]) + TLDF_ONE;
    endproperty
    a_floor_step: assert property (p_floor_step)
        else $error("floor step larger than one");
    // Hot monitor is off exactly while shutdown is blocked
    property p_uv_pair;
        cpu_hot_monitor_enable_q != shutdown_block_q;
    endproperty
    a_uv_pair: assert property (p_uv_pair)
        else $error("undervolt outputs disagree");
    // Voltage at or over its limit for three cycles ends the guard
    property p_uv_release;
        (core_voltage >= core_voltage_low_limit) [*3] |-> !shutdown_block_q;
    endproperty
    a_uv_release: assert property (p_uv_release)
        else $error("guard held with voltage restored");
    // Alert only while guarding and unmasked
    property p_uv_mask;
        undervolt_alert_q |-> shutdown_block_q && !$past(undervolt_alert_mask);
    endproperty
    a_uv_mask: assert property (p_uv_mask)
        else $error("undervolt alert wrong");
    // Status set is a single pulse
    property p_status_pulse;
        undervolt_status_set_q |=> !undervolt_status_set_q;
    endproperty
    a_status_pulse: assert property (p_status_pulse)
        else $error("status set held too long");
    // Each later client is asked two cycles after the last answer
    property p_poll_next;
        poll_req_q && poll_client_addr_q != TLDF_CLIENT_BASE
        |-> $past(poll_done, 2) && poll_client_addr_q <= 8'h33;
    endproperty
    a_poll_next: assert property (p_poll_next)
        else $error("poll request out of order");
endmodule

// File: tldf_regs_bench.sv
// Purpose: Self-checking bench for the limit and dynamic floor bank
// Assumes: ce held high; zone limits fixed for every scenario
// Notes: A read is checked two edges after its address is set
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH at %0t: got %h want %h", $time, g, e); end end
module tldf_regs_bench;
    import tldf_pkg::*;
    localparam int DW = 8;
    localparam int NCH = 3;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, lock_bit = 1'b0;
    logic overheat_signal_pin = 1'b0, monitor_tick = 1'b0, slow = 1'b0;
    logic standby_power = 1'b0, undervolt_alert_mask = 1'b0, poll_start = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
    logic [7:0] core_voltage = 8'hFF, core_voltage_low_limit = 8'h00;
    logic [NCH-1:0][DW-1:0] channel_temp = '0, floor_base = '0;
    logic [NCH-1:0][DW-1:0] zone_low_limit = {3{8'h20}};
    logic [NCH-1:0][DW-1:0] zone_high_limit = {3{8'h60}};
    logic [NCH-1:0][DW-1:0] fan_start_temperature_q;
    logic undervolt_status_set_q, undervolt_alert_q, cpu_hot_monitor_enable_q;
    logic shutdown_block_q, poll_req_q, poll_dual_zone_q, poll_done;
    logic [7:0] poll_client_addr_q;
    int failures = 0, checked = 0, status_seen = 0;
    logic [8:0] polls [$];
    logic [7:0] ra [12] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8A, 8'h8B,
        8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h89};
    logic [7:0] rv [12] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFB, 8'h64,
        8'h64, 8'h64, 8'h00, 8'h00, 8'h00};
    ////////////////////////////////////////////////////////////////
    // 10 MHz clock
    always #50 clk = ~clk;
    tldf_regs #(.DW(DW), .NCH(NCH)) dut (.clk, .rst, .ce, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rdata_q, .lock_bit, .overheat_signal_pin,
        .channel_temp, .zone_low_limit, .zone_high_limit, .floor_base,
        .monitor_tick, .fan_start_temperature_q, .core_voltage,
        .core_voltage_low_limit, .standby_power, .undervolt_alert_mask,
        .undervolt_status_set_q, .undervolt_alert_q, .cpu_hot_monitor_enable_q,
        .shutdown_block_q, .poll_start, .poll_done, .poll_req_q,
        .poll_client_addr_q, .poll_dual_zone_q);
    tldf_poll_client u_client (.clk, .rst, .slow, .poll_req_q, .poll_done);
    // Log poll requests and status pulses as they happen
    always @(posedge clk) begin
        if (poll_req_q === 1'b1)
            polls.push_back({poll_dual_zone_q, poll_client_addr_q});
        if (undervolt_status_set_q === 1'b1)
            status_seen++;
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask
    // One-cycle write strobe; the write lands on the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1;
        `CHK(reg_rdata_q, e)
    endtask
    // Sweep all addresses with a ramp; the unmapped one reads zero
    task automatic sweep(input logic [7:0] b, input logic w);
        for (int i = 0; i < 12; i++) begin
            if (w)
                wr(ra[i], 8'(b + i));
            else
                rc(ra[i], i == 11 ? 8'h00 : 8'(b + i));
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            monitor_tick <= 1'b1;
            @(posedge clk);
            monitor_tick <= 1'b0;
        end
    endtask
    task automatic fchk(input int ch, input logic [7:0] e);
        #1;
        `CHK(fan_start_temperature_q[ch], e)
    endtask
    task automatic uv(input logic [2:0] e);
        repeat (4) @(posedge clk);
        #1;
        `CHK({undervolt_alert_q, cpu_hot_monitor_enable_q, shutdown_block_q}, e)
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] cfg;
        logic [7:0] op [3];
        int n;
        op = '{default: 8'h64};
        do_reset;
        for (int i = 0; i < 12; i++)
            rc(ra[i], rv[i]);
        sweep(8'h5A, 1'b1);
        sweep(8'h5A, 1'b0);
        lock_bit <= 1'b1;
        rc(8'h84, 8'h5A);
        sweep(8'h11, 1'b1);
        sweep(8'h5A, 1'b0);
        lock_bit <= 1'b0;
        // Capture one channel per pass; the others must keep theirs
        do_reset;
        for (int k = 0; k < 3; k++) begin
            wr(8'h8E, 8'h04 << k);
            channel_temp <= {3{8'(8'h20 + k)}};
            @(posedge clk);
            overheat_signal_pin <= 1'b1;
            repeat (3) @(posedge clk);
            overheat_signal_pin <= 1'b0;
            op[k] = 8'(8'h20 + k);
            for (int j = 0; j < 3; j++)
                rc(8'(8'h8B + j), op[j]);
        end
        // Hot channels step their floor down after the coded wait
        do_reset;
        floor_base <= {3{8'h40}};
        channel_temp <= {3{8'h70}};
        wr(8'h8E, 8'h20);
        ticks(7);
        fchk(0, 8'h40);
        fchk(1, 8'h40);
        ticks(1);
        fchk(0, 8'h3F);
        wr(8'h8F, 8'h08);
        wr(8'h8E, 8'hC1);
        ticks(15);
        fchk(0, 8'h40);
        fchk(1, 8'h40);
        ticks(1);
        fchk(1, 8'h3F);
        ticks(111);
        fchk(2, 8'h40);
        ticks(1);
        fchk(2, 8'h3F);
        fchk(1, 8'h38);
        // Cool channel raises its floor after the longer wait
        channel_temp <= '0;
        wr(8'h8E, 8'h20);
        ticks(15);
        fchk(0, 8'h40);
        ticks(1);
        fchk(0, 8'h41);
        // Core voltage dips just under its limit, then recovers
        do_reset;
        status_seen = 0;
        core_voltage_low_limit <= 8'h80;
        core_voltage <= 8'h90;
        standby_power <= 1'b1;
        wr(8'h8E, 8'h02);
        uv(3'b010);
        core_voltage <= 8'h7F;
        uv(3'b101);
        undervolt_alert_mask <= 1'b1;
        uv(3'b001);
        core_voltage <= 8'h81;
        uv(3'b010);
        `CHK(status_seen, 1)
        // Poll rounds: four clients answered promptly, two slowly
        do_reset;
        for (int k = 0; k < 2; k++) begin
            cfg = k == 0 ? 8'hE0 : 8'h40;
            n = int'(cfg[7:6]) + 1;
            slow <= k[0];
            polls.delete();
            wr(8'h88, cfg);
            @(posedge clk);
            poll_start <= 1'b1;
            @(posedge clk);
            poll_start <= 1'b0;
            for (int c = 0; c < 400 && polls.size() < n; c++)
                @(posedge clk);
            if (polls.size() < n) begin
                failures++;
                give_verdict;
            end
            repeat (30) @(posedge clk);
            `CHK(polls.size(), n)
            for (int j = 0; j < n; j++)
                `CHK(polls[j], {j > 0 && cfg[6-j], 8'(8'h30 + j)})
        end
        give_verdict;
    end
endmodule
bind tldf_regs tldf_regs_chk #(.DW(DW), .NCH(NCH)) u_chk (.clk, .rst, .ce,
    .reg_addr, .reg_wr, .reg_rdata_q, .lock_bit, .monitor_tick, .floor_base,
    .fan_start_temperature_q, .core_voltage, .core_voltage_low_limit,
    .undervolt_alert_mask, .undervolt_status_set_q, .undervolt_alert_q,
    .cpu_hot_monitor_enable_q, .shutdown_block_q, .poll_done, .poll_req_q,
    .poll_client_addr_q);
